// ===== branch_trace.sv
// Purpose: Branch history recorder with precise event sampling and counter
// Assumes: One retirement per cycle from the core, synchronous to clk_i
// Notes:   Registers reached over a plain port, read data one cycle later
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Every retired taken branch stores its source and target address in the history buffer.
// - The history buffer holds 16 source/target pairs as a rotating buffer.
// - The filter select register restricts recording by ring 0, ring 3 and branch category.
// - With all filter bits clear, every taken branch at every level is recorded.
// - Each set filter bit suppresses its category, so clearing bits 1, 3, 6 and 7 keeps ring-3 near calls, relative jumps and far branches.
// - Precise sampling counts all branches, near calls or conditional branches, all or only mispredicted.
// - A precise branch sample holds the branch target as its instruction pointer.
// - A taken sampled branch's pointer equals the newest history target; a not-taken one adds no entry.
// - After a counter overflow, sampling arms only after a shadow delay, and events in it are lost.
// - Once armed, the next qualifying event is captured.
// - Overflow freezes the history buffer after a delay, so branches in between still enter.
// - Retired-instruction samples freeze at the trigger; the interrupt waits until interrupts are enabled.
// - A huge count mask with invert makes the condition true, counting every cycle.
// - The floating-point assist event sees only x87 assists, not SSE ones.
// - Precise branch events use event code C4H.
// - Further precise events use codes C2H, C7H and F7H.
module branch_trace #(
  parameter int DEPTH = bt_pkg::DEPTH
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rstn_i,
  // Retirement stream
  input  wire bt_pkg::retire_s         ret_i,
  input  wire logic                    int_enabled_i,
  // Register port
  input  wire logic [bt_pkg::RA_W-1:0] reg_addr_i,
  input  wire logic [31:0]             reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic      [31:0]             reg_rdata_o,
  // Interrupt
  output logic                         irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [bt_pkg::ADDR_W-1:0] src_mem [DEPTH];
  logic [bt_pkg::ADDR_W-1:0] dst_mem [DEPTH];
  logic [bt_pkg::PTR_W-1:0]  tos_reg;
  logic [bt_pkg::FLT_W-1:0]  filter_reg;
  logic [31:0]               evsel_reg;
  logic [31:0]               reload_reg;
  logic [31:0]               count_reg;
  logic [31:0]               ctrl_reg;
  logic [bt_pkg::ST_W-1:0]   status_reg;
  logic [bt_pkg::ST_W-1:0]   mask_reg;
  logic                      frozen_reg;
  logic                      freeze_pend_reg;
  logic [bt_pkg::DLY_W-1:0]  freeze_cnt_reg;
  logic                      shadow_reg;
  logic [bt_pkg::DLY_W-1:0]  shadow_cnt_reg;
  logic                      armed_reg;
  logic                      irq_pend_reg;
  bt_pkg::sample_s           sample_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic branch_kept(input bt_pkg::retire_s r, input logic [bt_pkg::FLT_W-1:0] f);
    logic lvl_ok;
    logic cat_ok;
    lvl_ok = r.ring3 ? !f[bt_pkg::FLT_RING3] : !f[bt_pkg::FLT_RING0];
    unique case (r.kind)
      bt_pkg::BR_JCC:     cat_ok = !f[bt_pkg::FLT_JCC];
      bt_pkg::BR_NCALL:   cat_ok = !f[bt_pkg::FLT_NCALL];
      bt_pkg::BR_NRET:    cat_ok = !f[bt_pkg::FLT_NRET];
      bt_pkg::BR_IND_JMP: cat_ok = !f[bt_pkg::FLT_IND_JMP];
      bt_pkg::BR_REL_JMP: cat_ok = !f[bt_pkg::FLT_REL_JMP];
      bt_pkg::BR_FAR:     cat_ok = !f[bt_pkg::FLT_FAR];
      default:            cat_ok = 1'b0;
    endcase
    return lvl_ok && cat_ok;
  endfunction

  // Event occurrences this cycle for a given event selection
  function automatic logic [2:0] event_hits(input bt_pkg::retire_s r, input logic [31:0] sel);
    logic [7:0] code;
    logic [7:0] um;
    logic       typ;
    logic [2:0] n;
    code = sel[bt_pkg::EV_CODE_LSB +: 8];
    um   = sel[bt_pkg::EV_UMASK_LSB +: 8];
    typ  = 1'b0;
    n    = 3'h0;
    unique case (um & ~(8'h01 << bt_pkg::UM_MISP_BIT))
      bt_pkg::UM_COND:  typ = r.kind == bt_pkg::BR_JCC;
      bt_pkg::UM_NCALL: typ = r.kind == bt_pkg::BR_NCALL;
      default:          typ = 1'b1;
    endcase
    if (r.valid) begin
      unique case (code)
        bt_pkg::EVC_BRANCH:
          n = {2'h0, r.is_branch && typ && (!um[bt_pkg::UM_MISP_BIT] || r.mispred)};
        bt_pkg::EVC_INST:  n = 3'h1;
        bt_pkg::EVC_UOPS:  n = r.uops;
        bt_pkg::EVC_SSE:   n = {2'h0, r.sse_class};
        bt_pkg::EVC_FPAST: n = {2'h0, r.x87_assist};
        default:           n = 3'h0;
      endcase
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Event condition and count
  logic [2:0]  hits;
  logic [7:0]  cmask;
  logic        cond;
  logic [31:0] count_next;
  logic        ovf;
  logic        en;
  logic        record;

  assign hits  = event_hits(ret_i, evsel_reg);
  assign cmask = evsel_reg[bt_pkg::EV_CMASK_LSB +: 8];
  assign en    = evsel_reg[bt_pkg::EV_EN_BIT];
  always_comb begin
    // With a threshold, the condition is per cycle; invert may make it always true
    if (cmask != 8'h00) begin
      cond = ({5'h0, hits} >= cmask) ^ evsel_reg[bt_pkg::EV_INV_BIT];
    end else begin
      cond = hits != 3'h0;
    end
  end
  assign count_next = (cmask != 8'h00) ? count_reg + {31'h0, cond} : count_reg + {29'h0, hits};
  assign ovf        = en && (count_next < count_reg);
  assign record     = ret_i.valid && ret_i.is_branch && ret_i.taken && !frozen_reg &&
                      branch_kept(ret_i, filter_reg);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_reg <= 32'h0;
    end else if (reg_wr_i && reg_addr_i == bt_pkg::REG_COUNT) begin
      count_reg <= reg_wdata_i;
    end else if (ovf) begin
      count_reg <= reload_reg;
    end else if (en) begin
      count_reg <= count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // History buffer
  always_ff @(posedge clk_i) begin
    if (record) begin
      src_mem[tos_reg + 4'h1] <= ret_i.src;
      dst_mem[tos_reg + 4'h1] <= ret_i.dst;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tos_reg <= 4'h0;
    end else if (record) begin
      tos_reg <= tos_reg + 4'h1;
    end
  end

  // Freeze takes effect after a delay; branches in between still enter
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frozen_reg      <= 1'b0;
      freeze_pend_reg <= 1'b0;
      freeze_cnt_reg  <= '0;
    end else if (ovf && ctrl_reg[bt_pkg::CTRL_FREEZE_EN] && !frozen_reg && !freeze_pend_reg) begin
      // Overflow wins over a same-cycle unfreeze
      freeze_pend_reg <= 1'b1;
      freeze_cnt_reg  <= bt_pkg::DLY_W'(bt_pkg::FREEZE_CYC - 1);
    end else if (reg_wr_i && reg_addr_i == bt_pkg::REG_CTRL && reg_wdata_i[bt_pkg::CTRL_UNFREEZE]) begin
      frozen_reg      <= 1'b0;
      freeze_pend_reg <= 1'b0;
    end else if (freeze_pend_reg) begin
      if (freeze_cnt_reg == '0) begin
        frozen_reg      <= 1'b1;
        freeze_pend_reg <= 1'b0;
      end else begin
        freeze_cnt_reg <= freeze_cnt_reg - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shadow, arming and capture
  logic capture;
  assign capture = armed_reg && hits != 3'h0;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shadow_reg     <= 1'b0;
      shadow_cnt_reg <= '0;
      armed_reg      <= 1'b0;
    end else if (ovf && evsel_reg[bt_pkg::EV_PREC_BIT] && !shadow_reg && !armed_reg) begin
      // Overflow wins over a same-cycle disarm
      shadow_reg     <= 1'b1;
      shadow_cnt_reg <= bt_pkg::DLY_W'(bt_pkg::SHADOW_CYC - 1);
    end else if (reg_wr_i && reg_addr_i == bt_pkg::REG_CTRL && reg_wdata_i[bt_pkg::CTRL_DISARM]) begin
      shadow_reg <= 1'b0;
      armed_reg  <= 1'b0;
    end else if (shadow_reg) begin
      if (shadow_cnt_reg == '0) begin
        shadow_reg <= 1'b0;
        armed_reg  <= 1'b1;
      end else begin
        shadow_cnt_reg <= shadow_cnt_reg - 1'b1;
      end
    end else if (capture) begin
      armed_reg <= 1'b0;
    end
  end

  // Record is frozen at the triggering instruction
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sample_reg <= '0;
    end else if (capture) begin
      sample_reg.ip   <= ret_i.dst;
      sample_reg.code <= evsel_reg[bt_pkg::EV_CODE_LSB +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and output
  logic [bt_pkg::ST_W-1:0] ev_set;
  logic                    smp_done;
  assign smp_done = (capture || irq_pend_reg) && int_enabled_i;
  assign ev_set   = {smp_done, ovf};

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_pend_reg <= 1'b0;
    end else if (smp_done) begin
      irq_pend_reg <= 1'b0;
    end else if (capture) begin
      irq_pend_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_reg <= '0;
    end else if (reg_wr_i && reg_addr_i == bt_pkg::REG_STATUS) begin
      status_reg <= (status_reg & ~reg_wdata_i[bt_pkg::ST_W-1:0]) | ev_set;
    end else begin
      status_reg <= status_reg | ev_set;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_reg & mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      filter_reg <= '0;
      evsel_reg  <= 32'h0;
      reload_reg <= 32'h0;
      ctrl_reg   <= 32'h0;
      mask_reg   <= '0;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        bt_pkg::REG_FILTER: filter_reg <= reg_wdata_i[bt_pkg::FLT_W-1:0];
        bt_pkg::REG_EVSEL:  evsel_reg  <= reg_wdata_i;
        bt_pkg::REG_RELOAD: reload_reg <= reg_wdata_i;
        bt_pkg::REG_CTRL:   ctrl_reg   <= {31'h0, reg_wdata_i[bt_pkg::CTRL_FREEZE_EN]};
        bt_pkg::REG_MASK:   mask_reg   <= reg_wdata_i[bt_pkg::ST_W-1:0];
        default:            ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      if (reg_addr_i[7:4] == bt_pkg::REG_SRC0[7:4]) begin
        reg_rdata_o <= src_mem[reg_addr_i[3:0]];
      end else if (reg_addr_i[7:4] == bt_pkg::REG_DST0[7:4]) begin
        reg_rdata_o <= dst_mem[reg_addr_i[3:0]];
      end else begin
        unique case (reg_addr_i)
          bt_pkg::REG_FILTER: reg_rdata_o <= {24'h0, filter_reg};
          bt_pkg::REG_EVSEL:  reg_rdata_o <= evsel_reg;
          bt_pkg::REG_CTRL:   reg_rdata_o <= {29'h0, armed_reg, frozen_reg, ctrl_reg[0]};
          bt_pkg::REG_RELOAD: reg_rdata_o <= reload_reg;
          bt_pkg::REG_COUNT:  reg_rdata_o <= count_reg;
          bt_pkg::REG_STATUS: reg_rdata_o <= {30'h0, status_reg};
          bt_pkg::REG_MASK:   reg_rdata_o <= {30'h0, mask_reg};
          bt_pkg::REG_TOS:    reg_rdata_o <= {28'h0, tos_reg};
          bt_pkg::REG_SMP_IP: reg_rdata_o <= sample_reg.ip;
          bt_pkg::REG_SMP_EV: reg_rdata_o <= {24'h0, sample_reg.code};
          default:            reg_rdata_o <= 32'h0;
        endcase
      end
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

endmodule

// ===== bt_pkg.sv
// Purpose: Constants and types for the branch trace and precise sampling block
// Assumes: 25 MHz core clock, single domain
// Notes:   Register offsets and layouts are word indices on the plain register port
package bt_pkg;

  localparam int ADDR_W  = 32;
  localparam int DEPTH   = 16;
  localparam int PTR_W   = 4;
  localparam int RA_W    = 8;

  // Register map (word addresses on the register port)
  localparam logic [RA_W-1:0] REG_FILTER  = 8'h00;
  localparam logic [RA_W-1:0] REG_EVSEL   = 8'h01;
  localparam logic [RA_W-1:0] REG_CTRL    = 8'h02;
  localparam logic [RA_W-1:0] REG_RELOAD  = 8'h03;
  localparam logic [RA_W-1:0] REG_COUNT   = 8'h04;
  localparam logic [RA_W-1:0] REG_STATUS  = 8'h05;
  localparam logic [RA_W-1:0] REG_MASK    = 8'h06;
  localparam logic [RA_W-1:0] REG_TOS     = 8'h07;
  localparam logic [RA_W-1:0] REG_SMP_IP  = 8'h08;
  localparam logic [RA_W-1:0] REG_SMP_EV  = 8'h09;
  localparam logic [RA_W-1:0] REG_SRC0    = 8'h20;
  localparam logic [RA_W-1:0] REG_DST0    = 8'h30;

  // Filter select bits: a set bit suppresses the category
  localparam int FLT_RING0   = 0;
  localparam int FLT_RING3   = 1;
  localparam int FLT_JCC     = 2;
  localparam int FLT_NCALL   = 3;
  localparam int FLT_NRET    = 4;
  localparam int FLT_IND_JMP = 5;
  localparam int FLT_REL_JMP = 6;
  localparam int FLT_FAR     = 7;
  localparam int FLT_W       = 8;

  // Event select field
  localparam int EV_CODE_LSB = 0;
  localparam int EV_UMASK_LSB = 8;
  localparam int EV_CMASK_LSB = 16;
  localparam int EV_INV_BIT  = 24;
  localparam int EV_EN_BIT   = 25;
  localparam int EV_PREC_BIT = 26;

  localparam logic [7:0] EVC_BRANCH = 8'hc4;
  localparam logic [7:0] EVC_INST   = 8'hc0;
  localparam logic [7:0] EVC_UOPS   = 8'hc2;
  localparam logic [7:0] EVC_SSE    = 8'hc7;
  localparam logic [7:0] EVC_FPAST  = 8'hf7;

  // Branch event unit masks
  localparam logic [7:0] UM_ALL      = 8'h00;
  localparam logic [7:0] UM_COND     = 8'h01;
  localparam logic [7:0] UM_NCALL    = 8'h02;
  localparam int         UM_MISP_BIT = 7;

  // Control register bits
  localparam int CTRL_FREEZE_EN = 0;
  localparam int CTRL_UNFREEZE  = 1;
  localparam int CTRL_DISARM    = 2;

  // Status / mask bits
  localparam int ST_OVF    = 0;
  localparam int ST_SAMPLE = 1;
  localparam int ST_W      = 2;

  // Timing
  localparam int SHADOW_NS     = 400;
  localparam int FREEZE_NS     = 200;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SHADOW_CYC    = (SHADOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FREEZE_CYC    = (FREEZE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W         = 5;

  typedef enum logic [2:0] {
    BR_JCC, BR_NCALL, BR_NRET, BR_IND_JMP, BR_REL_JMP, BR_FAR
  } br_kind_e;

  // One retired instruction from the core
  typedef struct packed {
    logic              valid;
    logic              is_branch;
    logic              taken;
    logic              mispred;
    logic              ring3;
    logic              x87_assist;
    logic              sse_class;
    logic [2:0]        uops;
    br_kind_e          kind;
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
  } retire_s;

  // Captured precise sample
  typedef struct packed {
    logic [ADDR_W-1:0] ip;
    logic [7:0]        code;
  } sample_s;

endpackage

// ===== core_retire_model.sv
// Purpose: Behavioural model of the core retirement stream
// Assumes: One retirement per call, launched just after a rising edge
// Notes:   Idle cycles carry inverted fields with valid low
`timescale 1ns/1ps
module core_retire_model (
  // Clock
  input  wire logic      clk_i,
  // Retirement stream
  output bt_pkg::retire_s ret_o
);
  bt_pkg::retire_s last;

  initial ret_o = '0;
  initial last = '0;

  // One retirement, then gap idle cycles
  task automatic send(input bt_pkg::retire_s r, input int gap);
    @(posedge clk_i);
    ret_o <= r;
    last = r;
    for (int i = 0; i < gap; i++) begin
      @(posedge clk_i);
      ret_o <= bt_pkg::retire_s'({1'b0, ~last[$bits(bt_pkg::retire_s)-2:0]});
    end
  endtask
endmodule

// ===== branch_trace_chk.sv
// Purpose: Port-level assertions for the branch trace block
// Assumes: One clock; software state mirrored from register writes
// Notes:   History checks stop once filtering or freezing is used
`timescale 1ns/1ps
module branch_trace_chk #(
  parameter int DEPTH = bt_pkg::DEPTH
) (
  // Clock and reset
  input wire logic                    clk_i,
  input wire logic                    rstn_i,
  // Retirement stream
  input wire bt_pkg::retire_s         ret_i,
  input wire logic                    int_enabled_i,
  // Register port and interrupt
  input wire logic [bt_pkg::RA_W-1:0] reg_addr_i,
  input wire logic [31:0]             reg_wdata_i,
  input wire logic                    reg_wr_i,
  input wire logic                    reg_rd_i,
  input wire logic [31:0]             reg_rdata_o,
  input wire logic                    irq_o
);
  logic [7:0]  filt_q;
  logic [1:0]  mask_q;
  logic [10:0] mode_q;
  logic        off_q;
  logic [3:0]  tos_q;
  logic        seen_q;
  logic [31:0] src_q;
  logic [31:0] dst_q;
  logic        rec;
  logic        live;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  assign rec  = ret_i.valid && ret_i.is_branch && ret_i.taken && !off_q;
  assign live = seen_q && !off_q;

////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      filt_q <= '0;
      mask_q <= '0;
      mode_q <= '0;
      off_q  <= 1'b0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == bt_pkg::REG_FILTER) begin
        filt_q <= reg_wdata_i[7:0];
      end
      if (reg_addr_i == bt_pkg::REG_MASK) begin
        mask_q <= reg_wdata_i[1:0];
      end
      if (reg_addr_i == bt_pkg::REG_EVSEL) begin
        mode_q <= reg_wdata_i[26:16];
      end
      if ((reg_addr_i == bt_pkg::REG_FILTER && reg_wdata_i[7:0] != 8'h00) ||
          (reg_addr_i == bt_pkg::REG_CTRL && reg_wdata_i[0])) begin
        off_q <= 1'b1;
      end
    end
  end

  // Expected newest history entry
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tos_q  <= '0;
      seen_q <= 1'b0;
      src_q  <= '0;
      dst_q  <= '0;
    end else if (rec) begin
      tos_q  <= tos_q + 4'h1;
      seen_q <= 1'b1;
      src_q  <= ret_i.src;
      dst_q  <= ret_i.dst;
    end
  end

////////////////////////////////////////////////////////////
  sequence rd_at(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  sequence two_count_reads;
    rd_at(bt_pkg::REG_COUNT) ##2 rd_at(bt_pkg::REG_COUNT);
  endsequence

  rd_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  filter_back_a: assert property (rd_at(bt_pkg::REG_FILTER) |=> reg_rdata_o == {24'h0, $past(filt_q)})
    else $error("filter readback wrong");
  tos_track_a: assert property (rd_at(bt_pkg::REG_TOS) ##0 !off_q |=> reg_rdata_o[3:0] == $past(tos_q))
    else $error("top pointer wrong");
  src_newest_a: assert property (rd_at({4'h2, tos_q}) ##0 live |=> reg_rdata_o == $past(src_q))
    else $error("newest source wrong");
  dst_newest_a: assert property (rd_at({4'h3, tos_q}) ##0 live |=> reg_rdata_o == $past(dst_q))
    else $error("newest target wrong");
  irq_mask_a: assert property (irq_o |-> $past(mask_q) != 2'b00)
    else $error("interrupt with all causes masked");
  irq_drop_a: assert property (reg_wr_i && reg_addr_i == bt_pkg::REG_MASK && reg_wdata_i[1:0] == 2'b00 |-> ##2 !irq_o)
    else $error("interrupt stays after mask cleared");
  cycle_count_a: assert property (two_count_reads ##0 mode_q == 11'h3ff |=> reg_rdata_o == $past(reg_rdata_o, 2) + 32'h2)
    else $error("count not one per cycle");
endmodule

bind branch_trace branch_trace_chk #(.DEPTH(DEPTH)) i_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .ret_i(ret_i), .int_enabled_i(int_enabled_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o)
);

// ===== tb_branch_trace.sv
// Purpose: Self-checking bench for the branch trace block
// Assumes: Core model drives retirements, bench drives registers
// Notes:   Each scenario task judges its own results
`timescale 1ns/1ps
module tb_branch_trace;
  logic            clk_i = 1'b0;
  logic            rstn_i = 1'b0;
  logic            int_en = 1'b1;
  logic            wr_s = 1'b0;
  logic            rd_s = 1'b0;
  logic [7:0]      addr = 8'h00;
  logic [31:0]     wdata = 32'h0;
  logic [31:0]     rdata;
  logic            irq;
  bt_pkg::retire_s ret;
  logic [31:0]     rv;
  logic [31:0]     t0;
  int              error_cnt = 0;
  int              check_count = 0;

  branch_trace i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .ret_i(ret), .int_enabled_i(int_en), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .irq_o(irq));
  core_retire_model i_core (.clk_i(clk_i), .ret_o(ret));

  always #20 clk_i = ~clk_i;

////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_s  <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_i);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a, rv);
    chk(n, e, rv);
  endtask

  function automatic bt_pkg::retire_s op(input logic x, input logic s, input logic [2:0] u);
    op = '0;
    op.valid = 1'b1;
    op.x87_assist = x;
    op.sse_class = s;
    op.uops = u;
  endfunction

  function automatic bt_pkg::retire_s br(input bt_pkg::br_kind_e k, input logic tk, input logic r3,
                                         input logic [31:0] d);
    br = op(1'b0, 1'b0, 3'h1);
    br.is_branch = 1'b1;
    br.taken = tk;
    br.ring3 = r3;
    br.kind = k;
    br.src = ~d;
    br.dst = d;
  endfunction

////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk("filter", bt_pkg::REG_FILTER, 32'h0);
    rchk("tos", bt_pkg::REG_TOS, 32'h0);
    rchk("unmapped", 8'h1f, 32'h0);
    chk("irq", 32'h0, 32'(irq));
    $display("done reset");
  endtask

  task automatic t_record;
    for (int i = 1; i <= 17; i++) begin
      i_core.send(br(bt_pkg::br_kind_e'(i % 6), 1'b1, i[0], 32'h1000 + i), 0);
    end
    i_core.send(br(bt_pkg::BR_JCC, 1'b0, 1'b0, 32'h9999), 1);
    rchk("tos", bt_pkg::REG_TOS, 32'h1);
    rchk("src1", bt_pkg::REG_SRC0 + 8'h1, ~32'h1011);
    rchk("dst1", bt_pkg::REG_DST0 + 8'h1, 32'h1011);
    rchk("dst0", bt_pkg::REG_DST0, 32'h1010);
    rchk("dst2", bt_pkg::REG_DST0 + 8'h2, 32'h1002);
    $display("done record");
  endtask

  task automatic t_sample;
    @(posedge clk_i);
    int_en <= 1'b0;
    wr(bt_pkg::REG_MASK, 32'h2);
    wr(bt_pkg::REG_COUNT, 32'hffff_ffff);
    wr(bt_pkg::REG_EVSEL, 32'h0600_02c4);
    i_core.send(br(bt_pkg::BR_NCALL, 1'b1, 1'b1, 32'h2000), 2);
    i_core.send(br(bt_pkg::BR_NCALL, 1'b1, 1'b1, 32'h2100), 12);
    i_core.send(br(bt_pkg::BR_JCC, 1'b1, 1'b1, 32'h2200), 0);
    i_core.send(br(bt_pkg::BR_NCALL, 1'b1, 1'b1, 32'h2300), 2);
    rchk("smp ip", bt_pkg::REG_SMP_IP, 32'h2300);
    rchk("smp ev", bt_pkg::REG_SMP_EV, 32'hc4);
    rd(bt_pkg::REG_TOS, t0);
    rchk("newest", {4'h3, t0[3:0]}, 32'h2300);
    rchk("status", bt_pkg::REG_STATUS, 32'h1);
    chk("irq held", 32'h0, 32'(irq));
    @(posedge clk_i);
    int_en <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 chk("irq", 32'h1, 32'(irq));
    wr(bt_pkg::REG_MASK, 32'h0);
    rchk("status kept", bt_pkg::REG_STATUS, 32'h3);
    chk("irq masked", 32'h0, 32'(irq));
    wr(bt_pkg::REG_MASK, 32'h2);
    wr(bt_pkg::REG_STATUS, 32'h3);
    rchk("cleared", bt_pkg::REG_STATUS, 32'h0);
    chk("irq off", 32'h0, 32'(irq));
    wr(bt_pkg::REG_EVSEL, 32'h0);
    $display("done sample");
  endtask

  task automatic t_filter;
    wr(bt_pkg::REG_FILTER, 32'h35);
    rchk("filter", bt_pkg::REG_FILTER, 32'h35);
    rd(bt_pkg::REG_TOS, t0);
    for (int k = 0; k < 12; k++) begin
      i_core.send(br(bt_pkg::br_kind_e'(k % 6), 1'b1, k >= 6, 32'h3000 + k), int'(k == 11));
    end
    rchk("tos", bt_pkg::REG_TOS, {28'h0, t0[3:0] + 4'h3});
    rchk("last", {4'h3, t0[3:0] + 4'h3}, 32'h300b);
    rchk("prev", {4'h3, t0[3:0] + 4'h2}, 32'h300a);
    wr(bt_pkg::REG_FILTER, 32'h0);
    $display("done filter");
  endtask

  task automatic t_freeze;
    wr(bt_pkg::REG_CTRL, 32'h1);
    wr(bt_pkg::REG_COUNT, 32'hffff_ffff);
    wr(bt_pkg::REG_EVSEL, 32'h0600_00c4);
    rd(bt_pkg::REG_TOS, t0);
    i_core.send(br(bt_pkg::BR_REL_JMP, 1'b1, 1'b0, 32'h4000), 1);
    i_core.send(br(bt_pkg::BR_REL_JMP, 1'b1, 1'b0, 32'h4100), 8);
    wr(bt_pkg::REG_CTRL, 32'h5);
    i_core.send(br(bt_pkg::BR_REL_JMP, 1'b1, 1'b0, 32'h4200), 1);
    rchk("frozen", bt_pkg::REG_TOS, {28'h0, t0[3:0] + 4'h2});
    rchk("disarmed", bt_pkg::REG_CTRL, 32'h3);
    rchk("no sample", bt_pkg::REG_SMP_IP, 32'h2300);
    wr(bt_pkg::REG_CTRL, 32'h2);
    i_core.send(br(bt_pkg::BR_REL_JMP, 1'b1, 1'b0, 32'h4300), 1);
    rchk("thawed", {4'h3, t0[3:0] + 4'h3}, 32'h4300);
    wr(bt_pkg::REG_EVSEL, 32'h0);
    $display("done freeze");
  endtask

  task automatic t_cycles;
    wr(bt_pkg::REG_EVSEL, 32'h03ff_00c0);
    rd(bt_pkg::REG_COUNT, t0);
    rd(bt_pkg::REG_COUNT, rv);
    chk("cycles", t0 + 32'h2, rv);
    wr(bt_pkg::REG_EVSEL, 32'h02ff_00c0);
    rd(bt_pkg::REG_COUNT, t0);
    rd(bt_pkg::REG_COUNT, rv);
    chk("no invert", t0, rv);
    $display("done cycles");
  endtask

  task automatic ev(input logic [15:0] uc, input bt_pkg::retire_s r, input logic [31:0] e);
    wr(bt_pkg::REG_EVSEL, {16'h0200, uc});
    wr(bt_pkg::REG_COUNT, 32'h0);
    i_core.send(r, 2);
    rchk("count", bt_pkg::REG_COUNT, e);
  endtask

  task automatic t_events;
    bt_pkg::retire_s m;
    m = br(bt_pkg::BR_NCALL, 1'b1, 1'b0, 32'h5000);
    ev(16'h00c4, br(bt_pkg::BR_JCC, 1'b0, 1'b0, 32'h5010), 32'h1);
    ev(16'h01c4, br(bt_pkg::BR_JCC, 1'b1, 1'b0, 32'h5020), 32'h1);
    ev(16'h01c4, m, 32'h0);
    ev(16'h02c4, m, 32'h1);
    ev(16'h82c4, m, 32'h0);
    m.mispred = 1'b1;
    ev(16'h82c4, m, 32'h1);
    ev(16'h00f7, op(1'b1, 1'b0, 3'h1), 32'h1);
    ev(16'h00f7, op(1'b0, 1'b1, 3'h1), 32'h0);
    ev(16'h00c2, op(1'b0, 1'b0, 3'h3), 32'h3);
    ev(16'h00c7, op(1'b0, 1'b1, 3'h1), 32'h1);
    ev(16'h00c0, op(1'b0, 1'b0, 3'h2), 32'h1);
    $display("done events");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    $display("watchdog expired");
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_record();
    t_sample();
    t_filter();
    t_freeze();
    t_cycles();
    t_events();
    end_of_test();
  end
endmodule
